// File: inc/prs_consts.svh
// Purpose: timing and reset constants for the power-up/reset sequencer
// Assumes: 40 MHz core clock (25 ns period)
// Notes:   times kept in their own units; cycle counts derived below
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

`define PRS_CLK_PERIOD_NS       25
`define PRS_CLK_MHZ             40
// host-side reset figures
`define PRS_RST_WIDTH_US        10
`define PRS_REFCLK_STABLE_US    1
// preamble readiness
`define PRS_MGMT_RESET_MS       2
`define PRS_MGMT_POWER_MS       200
`define PRS_PREAMBLE_BITS       32
// strap timing
`define PRS_STRAP_POWER_MS      200
`define PRS_STRAP_RESET_NS      120
`define PRS_STRAP_OUT_NS        64
// link pulse start delay, in milliseconds (1.5 s)
`define PRS_FLP_DELAY_MS        1500

// cycle counts: least times round up, longest times round down
`define PRS_RST_WIDTH_CYC   ((`PRS_RST_WIDTH_US*1000+`PRS_CLK_PERIOD_NS-1)/`PRS_CLK_PERIOD_NS)
`define PRS_REFCLK_CYC      ((`PRS_REFCLK_STABLE_US*1000+`PRS_CLK_PERIOD_NS-1)/`PRS_CLK_PERIOD_NS)
`define PRS_MGMT_RESET_CYC  (`PRS_MGMT_RESET_MS*1000*`PRS_CLK_MHZ)
`define PRS_MGMT_POWER_CYC  (`PRS_MGMT_POWER_MS*1000*`PRS_CLK_MHZ)
`define PRS_STRAP_POWER_CYC (`PRS_STRAP_POWER_MS*1000*`PRS_CLK_MHZ)
`define PRS_STRAP_RESET_CYC (`PRS_STRAP_RESET_NS/`PRS_CLK_PERIOD_NS)
`define PRS_STRAP_OUT_CYC   (`PRS_STRAP_OUT_NS/`PRS_CLK_PERIOD_NS)
`define PRS_FLP_DELAY_CYC   (`PRS_FLP_DELAY_MS*1000*`PRS_CLK_MHZ)

`define PRS_STRAP_W         8
`define PRS_CNT_W           32

`endif

// File: inc/prs_pkg.sv
// Purpose: types for the power-up/reset sequencer
// Assumes: prs_consts.svh supplies widths
// Notes:   one sequencing state machine in the top module
`include "prs_consts.svh"
package prs_pkg;
  // sequencing phases after reset release or power-up
  typedef enum logic [2:0] {
    PRS_HOLD,       // reset held low
    PRS_LATCH,      // waiting to sample straps
    PRS_TURN,       // straps latched, turning pins to outputs
    PRS_SETTLE,     // waiting for management readiness
    PRS_RUN         // management ready, waiting/sending link pulses
  } prs_state_t;

  // status carried out of the sequencer
  typedef struct packed {
    logic strapValid;   // straps have been captured
    logic strapOutEn;   // dual-purpose pins drive as outputs
    logic mgmtReady;    // management window open, preamble awaited
    logic flpEnable;    // link pulse transmission allowed
  } prs_status_t;
endpackage : prs_pkg

// File: design/prs_delay_timer.sv
// Purpose: one-shot cycle timer, done when count reaches limit
// Assumes: start is a one-cycle pulse; limit stable while running
// Notes:   done holds high until the next start, clear or reset
module prs_delay_timer #(
  parameter int CNT_W = 32
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  done
);
  logic [CNT_W-1:0] count_ff;   // elapsed cycles
  logic             run_ff;     // counting in progress
  logic             done_ff;    // limit reached

  wire logic hit = run_ff && (count_ff + 1'b1 >= limit);

  // count from start until the limit, then latch done
  always_ff @(posedge clock) begin
    if (!rst_n || clear) begin
      count_ff <= '0;
      run_ff   <= 1'b0;
      done_ff  <= 1'b0;
    end else if (start) begin
      count_ff <= '0;
      run_ff   <= 1'b1;
      done_ff  <= 1'b0;
    end else if (hit) begin
      run_ff   <= 1'b0;
      done_ff  <= 1'b1;
    end else if (run_ff) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  assign done = done_ff;
endmodule : prs_delay_timer

// File: design/prs_sequencer.sv
// Purpose: power-up and hardware-reset sequencing for a 10/100 PHY
// Assumes: rst_n is the device reset pin, synchronous to clock
// Notes:   counts above 4096 cycles are parameters for simulation
// Function
// - management ready within 2 ms of release
// - management ready within 200 ms of power-up
// - straps sampled within 200 ms of power-up
// - straps sampled about 120 ns after reset
// - strap pins become outputs 64 ns later
// - link pulses start 1.5 s after start
`include "prs_consts.svh"
module prs_sequencer
  import prs_pkg::*;
#(
  parameter int STRAP_W       = `PRS_STRAP_W,
  parameter int MGMT_RST_CYC  = `PRS_MGMT_RESET_CYC,
  parameter int MGMT_PWR_CYC  = `PRS_MGMT_POWER_CYC,
  parameter int STRAP_PWR_CYC = `PRS_STRAP_POWER_CYC,
  parameter int FLP_CYC       = `PRS_FLP_DELAY_CYC
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               refClockOk,
  input  wire logic               powerUp,
  input  wire logic [STRAP_W-1:0] strapIn,
  input  wire logic               mgmtDataIn,
  input  wire logic               mgmtClockRise,
  output logic      [STRAP_W-1:0] strapLatched,
  output logic                    strapOutEn,
  output logic                    mgmtReady,
  output logic                    mgmtEnable,
  output logic                    flpEnable,
  output logic                    coreRst_n,
  output prs_status_t             status
);
  localparam int CW = `PRS_CNT_W;
  localparam int STRAP_RST_CYC = (`PRS_STRAP_RESET_CYC < 1) ? 1
                                 : `PRS_STRAP_RESET_CYC;
  localparam int STRAP_OUT_CYC = (`PRS_STRAP_OUT_CYC < 1) ? 1
                                 : `PRS_STRAP_OUT_CYC;
  localparam logic [5:0] PRE_BITS = 6'(`PRS_PREAMBLE_BITS);

  // refuse settings the counters cannot serve
  if (STRAP_W < 1 || MGMT_RST_CYC < 1 || MGMT_PWR_CYC < 1 ||
      STRAP_PWR_CYC < 1 || FLP_CYC < 1) begin : gBadParam
    $error("prs_sequencer: bad parameter");
  end

  // widen a cycle count to the timer width
  function automatic logic [CW-1:0] cyc(input int n);
    return CW'(n);
  endfunction : cyc

  prs_state_t         state_ff;        // sequencing phase
  prs_state_t         nxt_state;       // next phase
  logic               fromPower_ff;    // sequence began at power-up
  logic [STRAP_W-1:0] strap_ff;        // captured straps
  logic               strapOut_ff;     // pins switched to outputs
  logic               mgmtReady_ff;    // preamble window open
  logic [5:0]         preCnt_ff;       // consecutive ones seen
  logic               mgmtEn_ff;       // preamble completed
  logic               flp_ff;          // link pulses enabled
  logic               rstSeen_ff;      // reset seen since power-up
  logic               rstPrev_ff;      // rst_n one cycle back

  // only the release edge launches a sequence; power-up start picks its counts
  wire logic relPulse  = rst_n && !rstPrev_ff;
  wire logic pwrStart  = powerUp && !rstSeen_ff;
  wire logic seqStart  = relPulse;

  // strap latch and management timers chosen per start source
  wire logic [CW-1:0] latchLim = fromPower_ff ? cyc(STRAP_PWR_CYC)
                                              : cyc(STRAP_RST_CYC);
  wire logic [CW-1:0] mgmtLim  = fromPower_ff ? cyc(MGMT_PWR_CYC)
                                              : cyc(MGMT_RST_CYC);

  logic latchDone;   // strap sample time reached
  logic turnDone;    // output switch time reached
  logic mgmtDone;    // management settle time reached
  logic flpDone;     // link pulse delay reached
  logic turnStart;   // pulse on strap capture

  assign turnStart = (state_ff == PRS_LATCH) && latchDone;

  // strap latch timer
  prs_delay_timer #(.CNT_W(CW)) uLatch (
    .clock (clock), .rst_n (rst_n), .clear (1'b0),
    .start (seqStart), .limit (latchLim), .done (latchDone)
  );

  // pin turnaround timer
  prs_delay_timer #(.CNT_W(CW)) uTurn (
    .clock (clock), .rst_n (rst_n), .clear (1'b0),
    .start (turnStart), .limit (cyc(STRAP_OUT_CYC)), .done (turnDone)
  );

  // management readiness timer
  prs_delay_timer #(.CNT_W(CW)) uMgmt (
    .clock (clock), .rst_n (rst_n), .clear (1'b0),
    .start (seqStart), .limit (mgmtLim), .done (mgmtDone)
  );

  // link pulse delay timer
  prs_delay_timer #(.CNT_W(CW)) uFlp (
    .clock (clock), .rst_n (rst_n), .clear (1'b0),
    .start (seqStart), .limit (cyc(FLP_CYC)), .done (flpDone)
  );

  // next phase
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PRS_HOLD:   if (relPulse) nxt_state = PRS_LATCH;
      PRS_LATCH:  if (latchDone) nxt_state = PRS_TURN;
      PRS_TURN:   if (turnDone) nxt_state = PRS_SETTLE;
      PRS_SETTLE: if (mgmtDone) nxt_state = PRS_RUN;
      PRS_RUN:    nxt_state = PRS_RUN;
    endcase
  end

  // release edge detect and power-up record; the reset that is already
  // low while the supply comes up is the power-up reset, so only a fall
  // of the pin after a run marks a pin reset
  always_ff @(posedge clock) begin
    rstPrev_ff <= rst_n;
    if (!powerUp) rstSeen_ff <= 1'b0;                  // supply dropped
    else if (!rst_n && rstPrev_ff) rstSeen_ff <= 1'b1; // pin reset fell
  end

  // phase register; the low reset pin holds all logic but the edge detect and power-up record idle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff     <= PRS_HOLD;
      fromPower_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (relPulse) fromPower_ff <= pwrStart;
    end
  end

  // strap capture and pin turnaround
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strap_ff    <= '0;
      strapOut_ff <= 1'b0;
    end else begin
      if (turnStart) strap_ff <= strapIn;
      if (state_ff == PRS_TURN && turnDone)
        strapOut_ff <= 1'b1;
    end
  end

  // management gate: open after settle, then await preamble
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mgmtReady_ff <= 1'b0;
      preCnt_ff    <= 6'h00;
      mgmtEn_ff    <= 1'b0;
    end else begin
      if (state_ff == PRS_SETTLE && mgmtDone)
        mgmtReady_ff <= 1'b1;
      if (mgmtReady_ff && !mgmtEn_ff && mgmtClockRise) begin
        if (!mgmtDataIn) preCnt_ff <= 6'h00;
        else if (preCnt_ff + 6'h01 >= PRE_BITS) mgmtEn_ff <= 1'b1;
        else preCnt_ff <= preCnt_ff + 6'h01;
      end
    end
  end

  // link pulse enable after the long delay
  always_ff @(posedge clock) begin
    if (!rst_n) flp_ff <= 1'b0;
    else if (flpDone && state_ff != PRS_HOLD)
      flp_ff <= 1'b1;
  end

  // outputs
  assign strapLatched = strap_ff;
  assign strapOutEn   = strapOut_ff;
  assign mgmtReady    = mgmtReady_ff;
  assign mgmtEnable   = mgmtEn_ff;
  assign flpEnable    = flp_ff;
  assign coreRst_n    = rst_n && refClockOk;
  assign status       = '{strapValid: (state_ff != PRS_HOLD) &&
                                      (state_ff != PRS_LATCH),
                          strapOutEn: strapOut_ff,
                          mgmtReady:  mgmtReady_ff,
                          flpEnable:  flp_ff};
endmodule : prs_sequencer

// File: tb/prs_sequencer_monitor.sv
// Purpose: timing checks at the sequencer ports
// Assumes: one clock, synchronous active-low reset
// Notes: relCnt_ff counts edges since reset release
module prs_sequencer_monitor
  import prs_pkg::*;
#(
  parameter int MGMT_RST_CYC  = 100,
  parameter int MGMT_PWR_CYC  = 140,
  parameter int STRAP_PWR_CYC = 20,
  parameter int FLP_CYC       = 300
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        refClockOk,
  input wire logic        powerUp,
  input wire logic        mgmtDataIn,
  input wire logic        mgmtClockRise,
  input wire logic        strapOutEn,
  input wire logic        mgmtReady,
  input wire logic        mgmtEnable,
  input wire logic        flpEnable,
  input wire logic        coreRst_n,
  input wire prs_status_t status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] relCnt_ff; // edges since release
  logic [7:0]  ones_ff;   // run of preamble ones
  logic        fresh_ff;  // next release uses power-up counts
  int          mgLim;     // readiness count of this run
  assign mgLim = fresh_ff ? MGMT_PWR_CYC : MGMT_RST_CYC;
  // helpers restart on reset; a pin reset ends the power-up path
  always_ff @(posedge clock) begin
    relCnt_ff <= rst_n ? relCnt_ff + 16'h0001 : 16'h0000;
    ones_ff   <= (!rst_n || !mgmtReady || (mgmtClockRise && !mgmtDataIn))
                 ? 8'h00 : ones_ff + {7'h00, mgmtClockRise};
    fresh_ff  <= !powerUp | (fresh_ff & (rst_n | relCnt_ff == 16'h0000));
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_latch;
    $rose(status.strapValid);
  endsequence
  sequence s_turn;
    !strapOutEn ##[1:4] strapOutEn;
  endsequence
  a_strap_reset_time: assert property (
    $rose(status.strapValid) && !fresh_ff |-> relCnt_ff inside {[3:8]})
    else $error("strap capture off time after reset");
  a_strap_power_time: assert property (
    $rose(status.strapValid) && fresh_ff
    |-> relCnt_ff inside {[STRAP_PWR_CYC-1:STRAP_PWR_CYC+5]})
    else $error("strap capture off time after power-up");
  a_pins_turn: assert property (
    s_latch |-> s_turn) else $error("strap pins did not turn");
  a_turn_order: assert property (
    strapOutEn |-> status.strapValid) else $error("pins turned early");
  a_mgmt_window: assert property (
    $rose(mgmtReady) |-> relCnt_ff >= mgLim - 1 && relCnt_ff <= mgLim + 5)
    else $error("management readiness off time");
  a_preamble_gate: assert property (
    $rose(mgmtEnable) |-> mgmtReady && ones_ff >= 8'h20)
    else $error("access enabled without full preamble");
  a_flp_delay: assert property (
    $rose(flpEnable) |-> relCnt_ff inside {[FLP_CYC-1:FLP_CYC+5]})
    else $error("link pulses off time");
  a_core_reset: assert property (
    disable iff (1'b0) !rst_n || !refClockOk |-> !coreRst_n)
    else $error("core left out of reset");
  a_reset_clear: assert property (
    disable iff (1'b0) !rst_n |=> status == 4'h0 && !mgmtEnable)
    else $error("outputs not cleared in reset");
endmodule : prs_sequencer_monitor

bind prs_sequencer prs_sequencer_monitor #(.MGMT_RST_CYC(MGMT_RST_CYC),
  .MGMT_PWR_CYC(MGMT_PWR_CYC), .STRAP_PWR_CYC(STRAP_PWR_CYC),
  .FLP_CYC(FLP_CYC)) mon (.clock(clock), .rst_n(rst_n),
  .refClockOk(refClockOk), .powerUp(powerUp), .mgmtDataIn(mgmtDataIn),
  .mgmtClockRise(mgmtClockRise), .strapOutEn(strapOutEn),
  .mgmtReady(mgmtReady), .mgmtEnable(mgmtEnable), .flpEnable(flpEnable),
  .coreRst_n(coreRst_n), .status(status));

// File: tb/prs_host_model.sv
// Purpose: host controller driving reset and management preamble
// Assumes: tasks are called by the bench top
// Notes: data line idles high as if pulled up
module prs_host_model (
  input  wire logic clock,
  output logic      rst_n,
  output logic      refClockOk,
  output logic      powerUp,
  output logic      mgmtDataIn,
  output logic      mgmtClockRise
);
  timeunit 1ns;
  timeprecision 1ps;
  // supplies off, reset low, data line pulled high
  initial {rst_n, refClockOk, powerUp, mgmtDataIn, mgmtClockRise} = 5'h02;
  // reset of 400 cycles with the clock settling inside it
  task automatic resetSeq();
    @(posedge clock);
    rst_n      <= 1'b0;
    refClockOk <= 1'b0;
    powerUp    <= 1'b1;
    repeat (340) @(posedge clock);
    refClockOk <= 1'b1;
    repeat (60) @(posedge clock);
    rst_n      <= 1'b1;
  endtask : resetSeq
  // one management clock rise every two core cycles
  task automatic sendBits(input int n, input logic v);
    repeat (n) begin
      @(posedge clock);
      mgmtDataIn    <= v;
      mgmtClockRise <= 1'b1;
      @(posedge clock);
      mgmtClockRise <= 1'b0;
    end
    mgmtDataIn <= 1'b1;
  endtask : sendBits
endmodule : prs_host_model

// File: tb/prs_sequencer_tb_top.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: small counts stand in for the long delays
// Notes: power-up run first, then a pin reset
module prs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MR = 100; // reset readiness count
  localparam int MP = 140; // power-up readiness count
  localparam int SP = 20;  // power-up strap count
  localparam int FL = 300; // link pulse count
  logic clock, rst_n, refClockOk, powerUp, mgmtDataIn, mgmtClockRise;
  logic strapOutEn, mgmtReady, mgmtEnable, flpEnable, coreRst_n;
  logic [7:0] strapIn, strapLatched;
  prs_pkg::prs_status_t status;
  int errors = 0, n_checks = 0, cyc = 0, relAt;
  prs_host_model host (.clock(clock), .rst_n(rst_n),
    .refClockOk(refClockOk), .powerUp(powerUp), .mgmtDataIn(mgmtDataIn),
    .mgmtClockRise(mgmtClockRise));
  prs_sequencer #(.MGMT_RST_CYC(MR), .MGMT_PWR_CYC(MP),
    .STRAP_PWR_CYC(SP), .FLP_CYC(FL)) uut (.clock(clock), .rst_n(rst_n),
    .refClockOk(refClockOk), .powerUp(powerUp), .strapIn(strapIn),
    .mgmtDataIn(mgmtDataIn), .mgmtClockRise(mgmtClockRise),
    .strapLatched(strapLatched), .strapOutEn(strapOutEn),
    .mgmtReady(mgmtReady), .mgmtEnable(mgmtEnable), .flpEnable(flpEnable),
    .coreRst_n(coreRst_n), .status(status));
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  task automatic checkBit(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask : checkBit
  task automatic checkByte(input string what, input logic [7:0] e,
                           input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : checkByte
  // bounded wait for one status flag
  task automatic waitBit(input int k, input int lim);
    int i;
    for (i = 0; i < lim && status[k] !== 1'b1; i++) @(posedge clock) #1;
    if (i == lim) begin
      errors++;
      summarize();
    end
  endtask : waitBit
  // timing and preamble checks shared by both release kinds
  task automatic checkRun(input int sLat, input int mRdy,
                          input logic [7:0] pat);
    int t;
    #1 relAt = cyc;
    waitBit(3, 400);
    t = cyc - relAt;
    checkBit("strap time", 1'b1,
             t >= sLat - 1 && t <= sLat + 3);
    checkByte("straps", pat, strapLatched);
    @(posedge clock) strapIn <= ~pat;
    waitBit(2, 8);
    checkBit("turn time", 1'b1, cyc - relAt - t <= 4);
    host.sendBits(32, 1'b1);
    #1 checkBit("early enable", 1'b0, mgmtEnable);
    waitBit(1, 400);
    t = cyc - relAt;
    checkBit("ready time", 1'b1,
             t >= mRdy - 1 && t <= mRdy + 4);
    host.sendBits(31, 1'b1);
    host.sendBits(1, 1'b0);
    host.sendBits(31, 1'b1);
    #1 checkBit("broken preamble", 1'b0, mgmtEnable);
    host.sendBits(1, 1'b1);
    repeat (2) @(posedge clock);
    #1 checkBit("preamble enable", 1'b1, mgmtEnable);
    waitBit(0, 400);
    t = cyc - relAt;
    checkBit("pulse time", 1'b1, t >= FL - 1 && t <= FL + 4);
    checkByte("held straps", pat, strapLatched);
  endtask : checkRun
  // power-up path: long strap and readiness counts
  task automatic scenPowerUp();
    @(posedge clock) strapIn <= 8'h5a;
    host.resetSeq();
    checkRun(SP, MP, 8'h5a);
  endtask : scenPowerUp
  // pin reset mid-run: outputs cleared, short counts; the release is
  // an nba on the edge, so look one step later when it has landed
  task automatic scenPinReset();
    host.resetSeq();
    #1 checkBit("cleared pulses", 1'b0, flpEnable);
    checkBit("core reset", 1'b1, coreRst_n);
    checkRun(5, MR, 8'ha5);
  endtask : scenPinReset
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    strapIn = 8'h00;
    scenPowerUp();
    scenPinReset();
    summarize();
  end
endmodule : prs_sequencer_tb_top
